// ===== hw/requant_pkg.sv
package requant_pkg;
    // Input sample format
    localparam int IN_W = 16;
    localparam int IN_FRAC = 8;
    // Output sample format: total bits and binary point from bit zero
    localparam int OUT_W = 12;
    localparam int OUT_FRAC = 4;
    // Scale factor port width, signed two's complement
    localparam int SCALE_W = 6;
    // Working width; holds the largest left shift without loss
    localparam int WORK_W = 64;
    // Entries of the output buffer
    localparam int BUF_DEPTH = 2;
    // Cycles from input acceptance to output valid when not stalled
    localparam int LATENCY = 2;
    // Reset values
    localparam logic [WORK_W-1:0] WORK_RESET = 64'h0000000000000000;
    localparam logic [OUT_W-1:0] OUT_RESET = 12'h000;
endpackage

// ===== hw/sample_buffer.sv
`timescale 1ns/1ps
// Two-entry buffer so that a stall downstream never drops a sample
module sample_buffer #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 2
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic push;
    logic pop;

    // Honest full and empty straight from the occupancy count
    assign wr_ready = (count != CW'(DEPTH));
    assign rd_valid = (count != '0);
    assign push = wr_valid && wr_ready;
    assign pop = rd_valid && rd_ready;
    assign rd_data = mem[rd_ptr];

    // Storage; no reset needed, entries are only read once written
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= wr_data;
        end
    end

    // Pointers wrap at the depth
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    // Occupancy
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end
endmodule

// ===== hw/fixed_point_requantizer.sv
`timescale 1ns/1ps
// Contract
// - Convert every sample to the configured output precision and binary point.
// - Accept signed two's complement or unsigned input samples.
// - Scaling only moves the binary point; container bits stay unchanged.
// - Output equals input times two to the signed integer scale k.
// - Missing fraction bits round to the nearest step, away from zero.
// - Exact halfway values take the candidate of larger magnitude.
// - Out-of-range results clamp to the most positive or negative value.
// - Output format is total bits plus binary point counted from bit zero.
module fixed_point_requantizer (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [requant_pkg::IN_W-1:0] in_data,
    input wire logic in_signed,
    input wire logic signed [requant_pkg::SCALE_W-1:0] scale_k,
    input wire logic out_signed,
    output logic out_valid,
    input wire logic out_ready,
    output logic [requant_pkg::OUT_W-1:0] out_data
);
    import requant_pkg::*;

    localparam int FRAC_DIFF = OUT_FRAC - IN_FRAC;
    localparam int SH_W = 8;

    logic signed [WORK_W-1:0] in_ext;
    logic signed [SH_W-1:0] shift;
    logic signed [SH_W-1:0] rshift;
    logic signed [WORK_W-1:0] half;
    logic signed [WORK_W-1:0] next_rounded;
    logic signed [WORK_W-1:0] rounded;
    logic stage_valid;
    logic stage_out_signed;
    logic stage_advance;
    logic buf_ready;
    logic signed [WORK_W-1:0] max_pos;
    logic signed [WORK_W-1:0] max_neg;
    logic [OUT_W-1:0] sat_data;

    // Extend the raw container by its own arithmetic type
    assign in_ext = in_signed ? WORK_W'(signed'(in_data))
                              : WORK_W'($unsigned(in_data));

    // Net shift of the integer pattern: scale plus change of fraction bits.
    // The container is never touched for scaling; only the point moves,
    // and the realignment into the output grid is what shifts.
    assign shift = SH_W'(scale_k) + SH_W'(FRAC_DIFF);
    assign rshift = -shift;
    assign half = (shift < 0) ? (WORK_W'(1) <<< (rshift - 1)) : WORK_W'(0);

    // Round half away from zero: negative values add one less than half,
    // so an exact tie on either sign lands on the larger magnitude.
    always_comb begin
        if (shift >= 0) begin
            next_rounded = in_ext <<< shift;
        end else if (in_ext < 0) begin
            next_rounded = (in_ext + half - WORK_W'(1)) >>> rshift;
        end else begin
            next_rounded = (in_ext + half) >>> rshift;
        end
    end

    // Single stage moves when it is empty or when the buffer can take its word
    assign stage_advance = !stage_valid || buf_ready;
    assign in_ready = stage_advance;

    // Scaled and rounded value; each sample stands alone
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rounded <= WORK_RESET;
            stage_out_signed <= 1'b0;
        end else if (stage_advance && in_valid) begin
            rounded <= next_rounded;
            stage_out_signed <= out_signed;
        end
    end

    // Stage occupancy
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_valid <= 1'b0;
        end else if (stage_advance) begin
            stage_valid <= in_valid;
        end
    end

    // Range of the output container by its arithmetic type
    assign max_pos = stage_out_signed ? ((WORK_W'(1) <<< (OUT_W - 1)) - WORK_W'(1))
                                      : ((WORK_W'(1) <<< OUT_W) - WORK_W'(1));
    assign max_neg = stage_out_signed ? -(WORK_W'(1) <<< (OUT_W - 1)) : WORK_W'(0);

    // Saturate after rounding, never wrap
    always_comb begin
        if (rounded > max_pos) begin
            sat_data = max_pos[OUT_W-1:0];
        end else if (rounded < max_neg) begin
            sat_data = max_neg[OUT_W-1:0];
        end else begin
            sat_data = rounded[OUT_W-1:0];
        end
    end

    // Output buffer carries back-pressure to the input
    sample_buffer #(
        .WIDTH(OUT_W),
        .DEPTH(BUF_DEPTH)
    ) u_out_buf (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .wr_valid(stage_valid),
        .wr_ready(buf_ready),
        .wr_data(sat_data),
        .rd_valid(out_valid),
        .rd_ready(out_ready),
        .rd_data(out_data)
    );
endmodule

// ===== test/sink_model.sv
`timescale 1ns/1ps
// Downstream logic; ready follows the stall request at once, so a stall never lags a cycle
module sink_model (
    input wire logic stall,
    output logic out_ready
);
    assign out_ready = !stall;
endmodule

// ===== test/fixed_point_requantizer_checker.sv
`timescale 1ns/1ps
// Values are judged only from an idle pipeline, where the two-edge answer holds
module fixed_point_requantizer_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic [requant_pkg::IN_W-1:0] in_data,
    input wire logic in_signed,
    input wire logic signed [requant_pkg::SCALE_W-1:0] scale_k,
    input wire logic out_signed,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [requant_pkg::OUT_W-1:0] out_data
);
    import requant_pkg::*;
    logic go, stuck, took;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // An accept one edge back still sits in the stage, so that edge is no idle start
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            took <= 1'b0;
        end else begin
            took <= in_valid && in_ready;
        end
    end
    // Idle accept with the receiver ready: stage and buffer both empty
    assign go = in_valid && in_ready && !out_valid && out_ready && !took;
    assign stuck = out_valid && !out_ready;
    property pv(k, d, v);
        go && in_signed && out_signed && scale_k == k && in_data == d ##1 out_ready
            |-> ##1 out_valid && out_data == v;
    endproperty
    data_hold_a: assert property (stuck |=> out_valid && $stable(out_data))
        else $error("stalled word changed");
    latency_two_a: assert property (go ##1 out_ready |-> ##1 out_valid)
        else $error("late word");
    exact_fmt_a: assert property (pv(6'h00, 16'h0160, 12'h016))
        else $error("bad exact");
    scale_up_a: assert property (pv(6'h01, 16'h0160, 12'h02C))
        else $error("bad scale");
    tie_neg_a: assert property (pv(6'h00, 16'hFFE8, 12'hFFE))
        else $error("bad tie");
    sat_pos_a: assert property (pv(6'h07, 16'h0100, 12'h7FF))
        else $error("bad high clamp");
    sat_neg_a: assert property (pv(6'h0F, 16'h8000, 12'h800))
        else $error("bad low clamp");
    uns_clamp_a: assert property (go && in_signed && in_data[15] && !out_signed
        ##1 out_ready |-> ##1 out_valid && out_data == 12'h000) else $error("bad zero clamp");
    cover property (go);
    cover property (stuck);
    cover property (in_valid && !in_ready);
endmodule
bind fixed_point_requantizer fixed_point_requantizer_checker chk (.core_clk(core_clk),
    .rst_n(rst_n), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
    .in_signed(in_signed), .scale_k(scale_k), .out_signed(out_signed),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));

// ===== test/fixed_point_requantizer_test.sv
`timescale 1ns/1ps
module fixed_point_requantizer_test;
    import requant_pkg::*;
    logic core_clk = 0, rst_n = 0, in_valid = 0, in_signed = 0, out_signed = 0, stall = 0;
    logic [IN_W-1:0] in_data = 16'h0000;
    logic signed [SCALE_W-1:0] scale_k = 6'h00;
    logic in_ready, out_valid, out_ready;
    logic [OUT_W-1:0] out_data;
    int n_mismatch = 0, n_tests = 0;
    always #12.5 core_clk = ~core_clk;
    fixed_point_requantizer dut (.core_clk(core_clk), .rst_n(rst_n), .in_valid(in_valid),
        .in_ready(in_ready), .in_data(in_data), .in_signed(in_signed), .scale_k(scale_k),
        .out_signed(out_signed), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data));
    sink_model sink (.stall(stall), .out_ready(out_ready));
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Inputs move a fixed 2 ns after the edge, never on it
    task automatic step();
        @(posedge core_clk);
        #2;
    endtask
    task automatic judge(string what, logic [OUT_W-1:0] exp, logic [OUT_W-1:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_out();
        for (int i = 0; i < 20 && out_valid !== 1'b1; i++) step();
        if (out_valid !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED out_valid expected 1 seen %b", out_valid);
            report_and_stop();
        end
    endtask
    // One sample through an idle pipeline, popped before the next
    task automatic one(logic [IN_W-1:0] d, logic s, logic [5:0] k, logic os, logic [11:0] e);
        {in_data, in_signed, scale_k, out_signed, in_valid} = {d, s, k, os, 1'b1};
        step();
        in_valid = 0;
        // Word must stand in the second cycle after the accepting edge
        step();
        judge("out_valid", 12'h001, OUT_W'(out_valid));
        wait_out();
        judge("out_data", e, out_data);
        step();
    endtask
    task automatic t_values();
        one(16'h0160, 1, 6'h00, 1, 12'h016);
        one(16'h0160, 1, 6'h01, 1, 12'h02C);
        one(16'h0100, 1, 6'h3C, 1, 12'h001);
        one(16'h0018, 1, 6'h00, 1, 12'h002);
        one(16'hFFE8, 1, 6'h00, 1, 12'hFFE);
        one(16'h0100, 1, 6'h07, 1, 12'h7FF);
        one(16'h8000, 1, 6'h0F, 1, 12'h800);
        one(16'hFFF0, 0, 6'h00, 0, 12'hFFF);
        one(16'hFFF0, 1, 6'h00, 0, 12'h000);
        one(16'hFFF0, 0, 6'h01, 0, 12'hFFF);
    endtask
    // Stall the receiver, fill until refused, then drain in order
    task automatic t_stall();
        int n = 0;
        logic took_d;
        stall = 1;
        {in_signed, out_signed, scale_k} = {2'b11, 6'h00};
        while (n < 8 && in_ready === 1'b1) begin
            {in_data, in_valid} = {IN_W'((n + 1) * 16), 1'b1};
            step();
            n++;
        end
        judge("taken", 12'h003, OUT_W'(n));
        // Offer a fourth word while refused; it must wait, not vanish
        in_data = IN_W'(64);
        step();
        judge("in_ready", 12'h000, OUT_W'(in_ready));
        stall = 0;
        for (int i = 1; i <= 4; i++) begin
            wait_out();
            judge("drain", OUT_W'(i), out_data);
            took_d = in_valid && in_ready;
            step();
            if (took_d) in_valid = 0;
        end
        in_valid = 0;
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        #2 rst_n = 1;
        t_values();
        t_stall();
        report_and_stop();
    end
endmodule
